// ---- hdl/ssp_pkg.sv ----
// Constants, encodings and reset values shared by the serial port files
package ssp_pkg;
  // ****************************************************************
  // Mode codes of serial_mode_select
  // ****************************************************************
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_SYNC = 3'h1;
  localparam logic [2:0] MODE_TWO_WIRE = 3'h2;
  localparam logic [2:0] MODE_UART7 = 3'h4;
  localparam logic [2:0] MODE_UART8 = 3'h5;
  localparam logic [2:0] MODE_UART9 = 3'h6;

  // ****************************************************************
  // Widths and lengths
  // ****************************************************************
  localparam int DATA_W = 9;
  localparam int CNT_W = 16;
  localparam int TX_FIFO_DEPTH = 2;
  localparam logic [3:0] SYNC_BITS = 4'h8;
  localparam logic [3:0] LEN7 = 4'h7;
  localparam logic [3:0] LEN8 = 4'h8;
  localparam logic [3:0] LEN9 = 4'h9;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int HALF_PERIOD_NS = 500;
  localparam int HALF_CYCLES = (HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic RST_TXD = 1'b1;
  localparam logic RST_RTS_N = 1'b1;
  localparam logic RST_SCLK = 1'b1;
  localparam logic RST_TX_EMPTY = 1'b1;
  localparam logic [2:0] RST_PIN_SYNC = 3'h7;

  // ****************************************************************
  // Transmitter states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SYNC = 3'b010,
    ST_UART = 3'b100
  } ssp_tx_state_t;
endpackage

// ---- hdl/ssp_stream_if.sv ----
// Valid/ready word stream between the port and its transmit buffer
interface ssp_stream_if #(
  parameter int W = 9
) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- hdl/ssp_fifo2.sv ----
// Small FIFO that buffers transmit words ahead of the transmit buffer
module ssp_fifo2 #(
  parameter int W = 9,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  ssp_stream_if.snk wr,
  ssp_stream_if.src rd
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("ssp_fifo2: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic in_rdy;
  } ssp_fifo_state_t;

  localparam ssp_fifo_state_t RST = '{in_rdy: 1'b1, default: '0};

  ssp_fifo_state_t r;
  ssp_fifo_state_t n;
  logic push;
  logic pop;

  assign wr.ready = r.in_rdy;
  assign rd.valid = (r.cnt != '0);
  assign rd.data = r.mem[r.rp];

  always_comb begin
    n = r;
    push = wr.valid && r.in_rdy;
    pop = rd.ready && (r.cnt != '0);
    if (push) begin
      n.mem[r.wp] = wr.data;
      n.wp = r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = r.rp + 1'b1;
    end
    if (push && !pop) begin
      n.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      n.cnt = r.cnt - 1'b1;
    end
    // Registered so the source sees ready straight from a flop
    n.in_rdy = (n.cnt != (AW + 1)'(DEPTH));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end
endmodule

// ---- hdl/ssp_top.sv ----
// Clock synchronous / asynchronous serial port with RTS/CTS handshake
module ssp_top #(
  parameter int HALF_DIV = ssp_pkg::HALF_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] serial_mode_select,
  input wire logic internal_clock_select,
  input wire logic clock_edge_polarity,
  input wire logic clock_open_drain,
  input wire logic rts_enable,
  input wire logic cts_enable,
  input wire logic transmit_enable,
  input wire logic rx_allow,
  input wire logic tx_irq_source_select,
  input wire logic error_signal_output_enable,
  input wire logic two_wire_mode_select,
  input wire logic two_wire_mode_option,
  input wire logic clock_delay,
  input wire logic tx_pending_clear,
  input wire logic rx_pending_clear,
  input wire logic rx_read,
  input wire logic [ssp_pkg::DATA_W-1:0] tx_wdata,
  input wire logic tx_wvalid,
  output logic tx_wready,
  input wire logic serial_clock_in,
  input wire logic serial_in,
  input wire logic cts_n_in,
  output logic serial_out,
  output logic serial_out_oe,
  output logic serial_clock_out,
  output logic serial_clock_oe,
  output logic rts_n,
  output logic rts_oe,
  output logic tx_buffer_empty,
  output logic [ssp_pkg::DATA_W-1:0] rx_data,
  output logic rx_buffer_full,
  output logic overrun_flag,
  output logic rx_pending_flag,
  output logic tx_pending_flag,
  output logic busy
);
  localparam int DW = ssp_pkg::DATA_W;
  localparam int CW = ssp_pkg::CNT_W;
  localparam logic [CW-1:0] HALF_LAST = CW'(HALF_DIV - 1);

  generate
    if (DW != 9 || HALF_DIV < 1 || HALF_DIV >= (1 << CW)) begin : g_bad_param
      $error("ssp_top: unsupported data width or clock divider");
    end
  endgenerate

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic is_uart(input logic [2:0] m);
    return (m == ssp_pkg::MODE_UART7) || (m == ssp_pkg::MODE_UART8) ||
           (m == ssp_pkg::MODE_UART9);
  endfunction

  function automatic logic [3:0] data_len(input logic [2:0] m);
    case (m)
      ssp_pkg::MODE_UART7: return ssp_pkg::LEN7;
      ssp_pkg::MODE_UART9: return ssp_pkg::LEN9;
      default: return ssp_pkg::LEN8;
    endcase
  endfunction

  // Start bit low, unused data bits forced high, stop bit high
  function automatic logic [DW+1:0] uart_frame(input logic [DW-1:0] d, input logic [3:0] len);
    logic [DW-1:0] mask;
    mask = {DW{1'b1}} >> (4'(DW) - len);
    return {1'b1, d | ~mask, 1'b0};
  endfunction

  typedef struct packed {
    ssp_pkg::ssp_tx_state_t st;
    logic [CW-1:0] half_cnt;
    logic [CW-1:0] rx_div;
    logic sclk_o;
    logic [DW+1:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [DW-1:0] rx_sh;
    logic [3:0] rx_cnt;
    logic rx_busy;
    logic rx_ph;
    logic [DW-1:0] tx_buf;
    logic tx_empty;
    logic [DW-1:0] rx_buf;
    logic rx_full;
    logic ovr;
    logic rx_pend;
    logic tx_pend;
    logic txd;
    logic txd_oe;
    logic sclk_oe;
    logic rts_n;
    logic rts_oe;
    logic busy;
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic [2:0] sy3;
    logic [2:0] filt;
    logic prev_both;
    logic [5:0] prev_cfg;
  } ssp_top_state_t;

  localparam ssp_top_state_t RST = '{
    st: ssp_pkg::ST_IDLE,
    sclk_o: ssp_pkg::RST_SCLK,
    tx_empty: ssp_pkg::RST_TX_EMPTY,
    txd: ssp_pkg::RST_TXD,
    rts_n: ssp_pkg::RST_RTS_N,
    sy1: ssp_pkg::RST_PIN_SYNC,
    sy2: ssp_pkg::RST_PIN_SYNC,
    sy3: ssp_pkg::RST_PIN_SYNC,
    filt: ssp_pkg::RST_PIN_SYNC,
    default: '0
  };

  ssp_top_state_t r;
  ssp_top_state_t n;

  ssp_stream_if #(.W(DW)) wr_if ();
  ssp_stream_if #(.W(DW)) rd_if ();

  assign wr_if.valid = tx_wvalid;
  assign wr_if.data = tx_wdata;
  assign tx_wready = wr_if.ready;
  assign rd_if.ready = r.tx_empty;

  ssp_fifo2 #(.W(DW), .DEPTH(ssp_pkg::TX_FIFO_DEPTH)) u_tx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .wr(wr_if),
    .rd(rd_if)
  );

  logic idle_lvl;
  logic mode_off;
  logic sync_mode;
  logic uart_mode;
  logic two_wire;
  logic [3:0] len;
  logic rxd;
  logic half_hit;
  logic rx_hit;
  logic ext_edge;
  logic away;
  logic back;
  logic rx_tick;
  logic start_ok;
  logic deliver;
  logic [DW-1:0] word;
  logic tx_set;
  logic rx_set;
  logic both;
  logic [5:0] cfg;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    n = r;
    deliver = 1'b0;
    word = '0;
    tx_set = 1'b0;
    rx_set = 1'b0;
    idle_lvl = ~clock_edge_polarity;
    mode_off = (serial_mode_select == ssp_pkg::MODE_OFF);
    sync_mode = (serial_mode_select == ssp_pkg::MODE_SYNC);
    two_wire = (serial_mode_select == ssp_pkg::MODE_TWO_WIRE);
    uart_mode = is_uart(serial_mode_select);
    len = data_len(serial_mode_select);

    // Pins: three stages, a level counts once stages two and three agree
    n.sy1 = {cts_n_in, serial_in, serial_clock_in};
    n.sy2 = r.sy1;
    n.sy3 = r.sy2;
    n.filt = (~(r.sy2 ^ r.sy3) & r.sy2) | ((r.sy2 ^ r.sy3) & r.filt);
    rxd = n.filt[1];

    // Shift clock: leaving idle drives data, returning to idle samples it
    half_hit = internal_clock_select && (r.st != ssp_pkg::ST_IDLE) && (r.half_cnt == HALF_LAST);
    ext_edge = !internal_clock_select && (n.filt[0] != r.filt[0]);
    away = internal_clock_select ? (half_hit && (r.sclk_o == idle_lvl)) :
           (ext_edge && (n.filt[0] != idle_lvl));
    back = internal_clock_select ? (half_hit && (r.sclk_o != idle_lvl)) :
           (ext_edge && (n.filt[0] == idle_lvl));

    if (internal_clock_select && (r.st != ssp_pkg::ST_IDLE)) begin
      n.half_cnt = half_hit ? '0 : r.half_cnt + 1'b1;
      if (half_hit) begin
        n.sclk_o = ~r.sclk_o;
      end
    end else begin
      n.half_cnt = '0;
      n.sclk_o = idle_lvl;
    end

    if (rd_if.valid && r.tx_empty) begin
      n.tx_buf = rd_if.data;
      n.tx_empty = 1'b0;
    end

    // ****************************************************************
    // Transmitter, which also makes the synchronous shift clock
    // ****************************************************************
    start_ok = transmit_enable && !r.tx_empty && (!cts_enable || !n.filt[2]) &&
               (internal_clock_select || (n.filt[0] == idle_lvl));
    case (r.st)
      ssp_pkg::ST_IDLE: begin
        if ((sync_mode || uart_mode) && start_ok) begin
          n.st = sync_mode ? ssp_pkg::ST_SYNC : ssp_pkg::ST_UART;
          n.tx_sh = sync_mode ? {3'h7, r.tx_buf[7:0]} : uart_frame(r.tx_buf, len);
          n.tx_empty = 1'b1;
          n.tx_cnt = '0;
          tx_set = !tx_irq_source_select;
        end
      end
      ssp_pkg::ST_SYNC: begin
        if (away) begin
          n.txd = r.tx_sh[0];
          n.tx_sh = {1'b1, r.tx_sh[DW+1:1]};
        end
        if (back) begin
          n.rx_sh = {rxd, r.rx_sh[DW-1:1]};
          n.tx_cnt = r.tx_cnt + 1'b1;
          if (r.tx_cnt == ssp_pkg::SYNC_BITS - 4'h1) begin
            n.st = ssp_pkg::ST_IDLE;
            deliver = rx_allow;
            word = {1'b0, rxd, r.rx_sh[DW-1:2]};
            tx_set = tx_irq_source_select;
          end
        end
      end
      ssp_pkg::ST_UART: begin
        if (away) begin
          n.txd = r.tx_sh[0];
          n.tx_sh = {1'b1, r.tx_sh[DW+1:1]};
          n.tx_cnt = r.tx_cnt + 1'b1;
          if (r.tx_cnt == len + 4'h2) begin
            n.st = ssp_pkg::ST_IDLE;
            n.txd = 1'b1;
            // Frame ends on an away edge; park the clock now, not a cycle after idle
            n.sclk_o = idle_lvl;
            tx_set = tx_irq_source_select;
          end
        end
      end
      default: begin
        n.st = ssp_pkg::ST_IDLE;
      end
    endcase

    // ****************************************************************
    // Asynchronous receiver, sampling at mid-bit
    // ****************************************************************
    rx_hit = (r.rx_div == HALF_LAST);
    rx_tick = internal_clock_select ? (rx_hit && !r.rx_ph) : back;
    if (uart_mode && rx_allow) begin
      if (!r.rx_busy) begin
        if (r.filt[1] && !rxd) begin
          n.rx_busy = 1'b1;
          n.rx_div = '0;
          n.rx_ph = 1'b0;
          n.rx_cnt = '0;
        end
      end else begin
        n.rx_div = rx_hit ? '0 : r.rx_div + 1'b1;
        if (rx_hit) begin
          n.rx_ph = ~r.rx_ph;
        end
        if (rx_tick) begin
          n.rx_cnt = r.rx_cnt + 1'b1;
          if (r.rx_cnt == '0) begin
            // A start bit gone high again was a glitch
            n.rx_busy = !rxd;
          end else if (r.rx_cnt <= len) begin
            n.rx_sh = {rxd, r.rx_sh[DW-1:1]};
          end else begin
            n.rx_busy = 1'b0;
            deliver = 1'b1;
            word = r.rx_sh >> (4'(DW) - len);
          end
        end
      end
    end else begin
      n.rx_busy = 1'b0;
    end

    if (mode_off) begin
      n.st = ssp_pkg::ST_IDLE;
      n.rx_busy = 1'b0;
      n.txd = 1'b1;
    end

    // ****************************************************************
    // Receive buffer and request flags; a set beats a same-cycle clear
    // ****************************************************************
    if (rx_read) begin
      n.rx_full = 1'b0;
      n.ovr = 1'b0;
    end
    if (deliver) begin
      // Contents are unspecified after an overrun; the newer word is kept
      n.rx_buf = word;
      n.rx_full = 1'b1;
      if (r.rx_full && !rx_read) begin
        n.ovr = 1'b1;
        rx_set = two_wire;
      end else begin
        rx_set = 1'b1;
      end
    end

    both = tx_irq_source_select && error_signal_output_enable;
    n.prev_both = both;
    if (both && !r.prev_both) begin
      tx_set = 1'b1;
    end
    cfg = {serial_mode_select, two_wire_mode_select, two_wire_mode_option, clock_delay};
    n.prev_cfg = cfg;
    if ((cfg != r.prev_cfg) && (two_wire || (r.prev_cfg[5:3] == ssp_pkg::MODE_TWO_WIRE))) begin
      tx_set = 1'b1;
      rx_set = 1'b1;
    end
    n.tx_pend = tx_set | (r.tx_pend & ~tx_pending_clear);
    n.rx_pend = rx_set | (r.rx_pend & ~rx_pending_clear);

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    n.rts_oe = !internal_clock_select && rts_enable && !mode_off;
    n.rts_n = n.rts_oe ? !(rx_allow && (n.st == ssp_pkg::ST_IDLE) && !n.rx_busy) : 1'b1;
    n.txd_oe = !mode_off;
    // Open drain only pulls low; the high level comes from the pull-up
    n.sclk_oe = sync_mode && internal_clock_select && (!clock_open_drain || !n.sclk_o);
    n.busy = (n.st != ssp_pkg::ST_IDLE) || n.rx_busy;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  assign serial_out = r.txd;
  assign serial_out_oe = r.txd_oe;
  assign serial_clock_out = r.sclk_o;
  assign serial_clock_oe = r.sclk_oe;
  assign rts_n = r.rts_n;
  assign rts_oe = r.rts_oe;
  assign tx_buffer_empty = r.tx_empty;
  assign rx_data = r.rx_buf;
  assign rx_buffer_full = r.rx_full;
  assign overrun_flag = r.ovr;
  assign rx_pending_flag = r.rx_pend;
  assign tx_pending_flag = r.tx_pend;
  assign busy = r.busy;
endmodule

// ---- testbench/ssp_chk.sv ----
// Concurrent checks of the serial port's handshake, shift clock and flags
module ssp_chk #(parameter int HALF_DIV = 2) (
  input logic clk,
  input logic rst_n,
  input logic [2:0] serial_mode_select,
  input logic internal_clock_select,
  input logic transmit_enable,
  input logic rx_allow,
  input logic tx_irq_source_select,
  input logic error_signal_output_enable,
  input logic serial_clock_out,
  input logic rts_n,
  input logic rts_oe,
  input logic tx_buffer_empty,
  input logic rx_buffer_full,
  input logic overrun_flag,
  input logic rx_pending_flag,
  input logic tx_pending_flag,
  input logic busy
);
  timeunit 1ns;
  timeprecision 100ps;
  // Covers start latency plus one half period with a generous margin
  localparam int T_START = 40;
  // ********
  // Properties
  // ********
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_ready;
    rts_oe && rx_allow && !busy;
  endsequence
  sequence s_rx_begins;
    rts_oe && $rose(busy);
  endsequence
  property p_rts_low;
    s_ready [*3] |-> !rts_n;
  endproperty
  a_rts_low: assert property (p_rts_low) else $error("rts_n high while ready");
  property p_rts_high;
    s_rx_begins |-> ##[0:2] rts_n;
  endproperty
  a_rts_high: assert property (p_rts_high) else $error("rts_n low in transfer");
  property p_rts_int;
    internal_clock_select && $past(internal_clock_select) |-> !rts_oe;
  endproperty
  a_rts_int: assert property (p_rts_int) else $error("rts driven on internal clock");
  property p_clk_start;
    $fell(tx_buffer_empty) && transmit_enable && internal_clock_select &&
      serial_mode_select == ssp_pkg::MODE_SYNC |-> ##[1:T_START] $changed(serial_clock_out);
  endproperty
  a_clk_start: assert property (p_clk_start) else $error("shift clock not started");
  property p_clk_hold;
    internal_clock_select && tx_buffer_empty && !busy && !$past(busy) |-> $stable(serial_clock_out);
  endproperty
  a_clk_hold: assert property (p_clk_hold) else $error("shift clock without word");
  property p_ovr;
    $rose(overrun_flag) |-> rx_buffer_full && $past(rx_buffer_full);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun flag without full buffer");
  property p_ovr_pend;
    $rose(overrun_flag) && !$past(rx_pending_flag) &&
      serial_mode_select == ssp_pkg::MODE_SYNC |-> !rx_pending_flag [*2];
  endproperty
  a_ovr_pend: assert property (p_ovr_pend) else $error("overrun set rx pending");
  property p_rx_pend;
    $rose(rx_buffer_full) |-> ##[0:2] rx_pending_flag;
  endproperty
  a_rx_pend: assert property (p_rx_pend) else $error("rx pending not set");
  property p_tx_both;
    $rose(tx_irq_source_select && error_signal_output_enable) |-> ##[0:3] tx_pending_flag;
  endproperty
  a_tx_both: assert property (p_tx_both) else $error("tx pending not set");
endmodule
bind ssp_top ssp_chk #(.HALF_DIV(HALF_DIV)) u_chk (.*);

// ---- testbench/ssp_partner.sv ----
// Far-side shift register device with its own frame clock
module ssp_partner (
  input wire logic sclk,
  input wire logic sout,
  output logic sin,
  output logic eclk
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tx_sh;
  logic [7:0] got;
  int n;
  initial begin
    eclk = 1'b1;
    sin = 1'b1;
    tx_sh = 8'h00;
    got = 8'h00;
    n = 0;
  end
  // ********
  // Shifting
  // ********
  always @(negedge sclk) begin
    sin = tx_sh[0];
    tx_sh = {1'b0, tx_sh[7:1]};
  end
  always @(posedge sclk) begin
    got = {sout, got[7:1]};
    n = n + 1;
    // Line not held after the frame: show no stale bit, but only past the hold time,
    // and before a back-to-back frame can drive its first bit
    if (n % 8 == 0) sin <= #15 ~sin;
  end
  task automatic load(input logic [7:0] b);
    tx_sh = b;
    n = 0;
  endtask
  // Clock runs only inside a frame and rests high between frames
  task automatic frame();
    repeat (8) begin
      #62.5 eclk = 1'b0;
      #62.5 eclk = 1'b1;
    end
  endtask
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench of the serial port against the far-side model
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, internal_clock_select, clock_edge_polarity, clock_open_drain;
  logic rts_enable, cts_enable, transmit_enable, rx_allow, tx_irq_source_select;
  logic error_signal_output_enable, two_wire_mode_select, two_wire_mode_option, clock_delay;
  logic tx_wvalid, tx_wready, cts_n_in, eclk, full_q, serial_out, serial_out_oe;
  logic serial_clock_out, serial_clock_oe, rts_n, rts_oe, tx_buffer_empty, rx_buffer_full;
  logic overrun_flag, rx_pending_flag, tx_pending_flag, busy, lb;
  logic [2:0] serial_mode_select, pls;
  logic [ssp_pkg::DATA_W-1:0] tx_wdata, rx_data;
  wire serial_clock_in, serial_in, p_sin, rx_read, rx_pending_clear, tx_pending_clear;
  logic [31:0] seed = 32'hb092;
  logic [8:0] exp_q[$];
  int fails = 0;
  int n_tests = 0;
  assign serial_clock_in = serial_clock_oe ? serial_clock_out : eclk;
  // Loopback for the asynchronous mode, the far-side model otherwise
  assign serial_in = lb ? serial_out : p_sin;
  assign {rx_read, rx_pending_clear, tx_pending_clear} = pls;
  ssp_top #(.HALF_DIV(8)) DUT (.*);
  ssp_partner p (.sclk(serial_clock_in), .sout(serial_out), .sin(p_sin), .eclk(eclk));
  // ********
  // Helpers
  // ********
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {8'h00, e}, {8'h00, g});
  endtask
  task automatic wait_hi(ref logic s, input string nm);
    for (int i = 0; i < 600 && s !== 1'b1; i++) @(posedge clk);
    chk1(nm, 1'b1, s);
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge clk);
    pls <= m;
    @(posedge clk);
    pls <= 3'h0;
  endtask
  task automatic push(input logic [8:0] w);
    @(posedge clk);
    tx_wdata <= w;
    tx_wvalid <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge clk);
      if (tx_wready === 1'b1) break;
    end
    tx_wvalid <= 1'b0;
    chk1("tx_wready", 1'b1, tx_wready);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Each reception that raises rx_buffer_full is compared with the oldest noted word
  always @(posedge clk) begin
    full_q <= rx_buffer_full;
    if (rst_n === 1'b1 && rx_buffer_full === 1'b1 && full_q === 1'b0) begin
      if (exp_q.size() == 0) chk("rx_data", ~rx_data, rx_data);
      else chk("rx_data", exp_q.pop_front(), rx_data);
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200us;
    fails++;
    stop_test();
  end
  initial begin
    logic [31:0] r;
    logic [7:0] w[3];
    {internal_clock_select, clock_edge_polarity, clock_open_drain, rts_enable, cts_enable,
     transmit_enable, rx_allow, tx_irq_source_select, error_signal_output_enable,
     two_wire_mode_select, two_wire_mode_option, clock_delay, tx_wvalid} = '0;
    rst_n = 1'b0;
    serial_mode_select = 3'h0;
    pls = 3'h0;
    lb = 1'b0;
    tx_wdata = '0;
    cts_n_in = 1'b1;
    cyc(2);
    rst_n <= 1'b1;
    cyc(2);
    chk1("serial_out_oe", 1'b0, serial_out_oe);
    serial_mode_select <= ssp_pkg::MODE_SYNC;
    {internal_clock_select, transmit_enable, rx_allow} <= 3'h7;
    cyc(4);
    chk1("rts_oe", 1'b0, rts_oe);
    chk1("busy", 1'b0, busy);
    for (int k = 0; k < 4; k++) begin
      r = xs();
      p.load(r[15:8]);
      exp_q.push_back({1'b0, r[15:8]});
      push({1'b0, r[7:0]});
      wait_hi(rx_buffer_full, "rx_buffer_full");
      chk("partner word", {1'b0, r[7:0]}, {1'b0, p.got});
      pulse(3'h4);
    end
    $display("test internal clock done");
    pulse(3'h3);
    clock_open_drain <= 1'b1;
    r = xs();
    p.load(r[7:0]);
    exp_q.push_back({1'b0, r[7:0]});
    push({1'b0, r[15:8]});
    push({1'b0, r[23:16]});
    wait_hi(rx_buffer_full, "rx_buffer_full");
    pulse(3'h2);
    wait_hi(overrun_flag, "overrun_flag");
    cyc(2);
    chk1("rx_pending_flag", 1'b0, rx_pending_flag);
    pulse(3'h4);
    clock_open_drain <= 1'b0;
    $display("test overrun done");
    {internal_clock_select, rts_enable, cts_enable} <= 3'h3;
    cyc(4);
    chk1("rts_n", 1'b0, rts_n);
    for (int k = 0; k < 3; k++) begin
      r = xs();
      w[k] = r[7:0];
      push({1'b0, w[k]});
    end
    cyc(20);
    chk1("busy", 1'b0, busy);
    chk1("tx_wready", 1'b0, tx_wready);
    cts_n_in <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      r = xs();
      p.load(r[7:0]);
      exp_q.push_back({1'b0, r[7:0]});
      cyc(10);
      chk1("rts_n", 1'b1, rts_n);
      p.frame();
      wait_hi(rx_buffer_full, "rx_buffer_full");
      chk("partner word", {1'b0, w[k]}, {1'b0, p.got});
      pulse(3'h4);
    end
    $display("test external clock done");
    pulse(3'h3);
    {tx_irq_source_select, error_signal_output_enable} <= 2'h3;
    cyc(4);
    chk1("tx_pending_flag", 1'b1, tx_pending_flag);
    pulse(3'h3);
    // Entering two-wire mode changes the configuration, which raises both the rx and tx requests
    serial_mode_select <= ssp_pkg::MODE_TWO_WIRE;
    cyc(4);
    chk1("rx_pending_flag", 1'b1, rx_pending_flag);
    pulse(3'h3);
    clock_delay <= 1'b1;
    cyc(4);
    chk1("tx_pending_flag", 1'b1, tx_pending_flag);
    serial_mode_select <= ssp_pkg::MODE_OFF;
    cyc(4);
    chk1("serial_out_oe", 1'b0, serial_out_oe);
    $display("test flags done");
    lb <= 1'b1;
    cts_enable <= 1'b0;
    internal_clock_select <= 1'b1;
    cyc(4);
    serial_mode_select <= ssp_pkg::MODE_UART8;
    cyc(4);
    for (int k = 0; k < 2; k++) begin
      r = xs();
      exp_q.push_back({1'b0, r[7:0]});
      push(r[8:0]);
      wait_hi(rx_buffer_full, "rx_buffer_full");
      pulse(3'h4);
    end
    $display("test uart loopback done");
    stop_test();
  end
endmodule
